// [rtl/sipc_ctrl.sv]
// mode, service gating and address-swap controller with apb registers
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/10ps
module sipc_ctrl #(
    parameter int CYC_PER_MS = sipc_pkg::CYC_PER_MS
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        SRST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // local redundancy cpu
    input  wire logic        CPU_PRESENT,
    input  wire logic        CPU_HEALTHY,
    input  wire logic        CPU_RUNNING,
    input  wire logic [1:0]  REDUNDANCY_STATE,
    input  wire logic        PEER_TO_PRIMARY,
    // network events in
    input  wire logic        ARP_REPLY,
    input  wire logic        SWAP_REQ_RX,
    input  wire logic        SWAP_RSP_RX,
    // network events out
    output logic             ARP_REQ_TX,
    output logic             SWAP_REQ_TX,
    output logic             SWAP_RSP_TX,
    output logic             OPEN_CLIENTS,
    output logic             LISTEN_SERVERS,
    // mode and address
    output logic      [1:0]  MODE,
    output logic             ADDR_PLUS_ONE,
    output logic             USE_DYN_ADDR,
    output logic             DUP_ADDR_DIAG,
    output logic      [6:0]  SVC_EN,
    output logic      [31:0] NET_ADDR
);

    if (CYC_PER_MS < 1) begin : g_chk
        $error("CYC_PER_MS must be positive");
    end

    typedef struct packed {
        sipc_pkg::sipc_phase_t phase;
        sipc_pkg::sipc_mode_t  mode;
        logic                  cfg_valid;
        logic                  nonred;
        logic [31:0]           cfg_addr;
        logic [15:0]           wdt_ms;
        logic [15:0]           arp_ms;
        logic [1:0]            prev_rs;
        logic                  prev_run;
        logic                  addr_sel;
        logic                  dyn;
        logic                  dup;
        logic [6:0]            svc;
        logic                  arp_tx;
        logic                  req_tx;
        logic                  rsp_tx;
        logic                  open_cl;
        logic                  listen;
        logic [31:0]           prdata;
        logic                  slverr;
        logic [31:0]           net_addr;
    } sipc_st_t;

    sipc_st_t              s_ff;
    sipc_st_t              nxt_s;
    logic                  wdt_start;
    logic [15:0]           wdt_tmo;
    logic                  wdt_exp;
    logic                  setup_w;
    logic                  wr_w;
    logic                  start_w;
    logic                  reload_w;
    logic                  go_in;
    logic                  go_out;
    logic                  go_off;
    logic                  back_sb;
    logic                  trig_w;
    sipc_pkg::sipc_mode_t  ev_mode;

    // =====================================================================
    // decoding helpers
    function automatic logic reg_hit(input logic [7:0] a);
        return a == sipc_pkg::A_CTRL || a == sipc_pkg::A_CFG_ADDR || a == sipc_pkg::A_STATUS ||
               a == sipc_pkg::A_CUR_ADDR || a == sipc_pkg::A_WDT_MS || a == sipc_pkg::A_ARP_MS;
    endfunction

    function automatic sipc_pkg::sipc_mode_t eval_mode(input logic present, input logic healthy,
                                                       input logic running, input logic nonred,
                                                       input logic [1:0] rs);
        if (nonred || !present || !healthy) begin
            return sipc_pkg::MODE_STANDALONE;
        end
        if (!running) begin
            return sipc_pkg::MODE_OFFLINE;
        end
        unique case (rs)
            sipc_pkg::RS_PRIMARY:    return sipc_pkg::MODE_PRIMARY;
            sipc_pkg::RS_STANDBY:    return sipc_pkg::MODE_SECONDARY;
            sipc_pkg::RS_OFFLINE:    return sipc_pkg::MODE_OFFLINE;
            sipc_pkg::RS_UNASSIGNED: return sipc_pkg::MODE_STANDALONE;
        endcase
    endfunction

    // primary and standalone run everything; the rest only serve
    function automatic logic [6:0] svc_for(input sipc_pkg::sipc_mode_t m);
        if (m == sipc_pkg::MODE_PRIMARY || m == sipc_pkg::MODE_STANDALONE) begin
            return sipc_pkg::SVC_ALL;
        end
        return sipc_pkg::SVC_SERVER;
    endfunction

    // the cpu elects one primary, so following its state splits the pair
    function automatic logic addr_for(input logic [1:0] rs);
        return rs == sipc_pkg::RS_STANDBY;
    endfunction

    // =====================================================================
    // bus strobes and triggers
    assign setup_w  = PSEL && !PENABLE;
    assign wr_w     = PSEL && PENABLE && PWRITE && reg_hit(PADDR);
    assign start_w  = wr_w && PADDR == sipc_pkg::A_CTRL && PWDATA[sipc_pkg::CTRL_START];
    assign reload_w = wr_w && PADDR == sipc_pkg::A_CTRL && PWDATA[sipc_pkg::CTRL_RELOAD];
    assign ev_mode  = eval_mode(CPU_PRESENT, CPU_HEALTHY, CPU_RUNNING, s_ff.nonred, REDUNDANCY_STATE);

    assign go_in   = s_ff.prev_rs == sipc_pkg::RS_STANDBY && REDUNDANCY_STATE == sipc_pkg::RS_PRIMARY
                     && s_ff.mode == sipc_pkg::MODE_SECONDARY;
    assign go_out  = s_ff.prev_rs == sipc_pkg::RS_PRIMARY && REDUNDANCY_STATE == sipc_pkg::RS_OFFLINE
                     && s_ff.mode == sipc_pkg::MODE_PRIMARY;
    assign go_off  = (REDUNDANCY_STATE == sipc_pkg::RS_OFFLINE && s_ff.prev_rs != sipc_pkg::RS_OFFLINE)
                     || (s_ff.prev_run && !CPU_RUNNING);
    assign back_sb = s_ff.prev_rs == sipc_pkg::RS_OFFLINE && REDUNDANCY_STATE == sipc_pkg::RS_STANDBY
                     && s_ff.mode == sipc_pkg::MODE_OFFLINE;
    assign trig_w  = go_in || go_out || go_off || back_sb || reload_w;

    // =====================================================================
    // next state
    always_comb begin
        logic [31:0] rd;
        rd             = '0;
        nxt_s          = s_ff;
        wdt_start      = 1'b0;
        // the probe keeps its own limit while the shared watchdog runs
        wdt_tmo        = (s_ff.phase == sipc_pkg::PH_PROBE) ? s_ff.arp_ms : s_ff.wdt_ms;
        nxt_s.arp_tx   = 1'b0;
        nxt_s.req_tx   = 1'b0;
        nxt_s.rsp_tx   = 1'b0;
        nxt_s.open_cl  = 1'b0;
        nxt_s.listen   = 1'b0;
        nxt_s.prev_rs  = REDUNDANCY_STATE;
        nxt_s.prev_run = CPU_RUNNING;

        // read data latched in the setup cycle, shown in the access cycle
        if (setup_w) begin
            unique case (PADDR)
                sipc_pkg::A_CTRL: begin
                    rd[sipc_pkg::CTRL_CFG_VALID] = s_ff.cfg_valid;
                    rd[sipc_pkg::CTRL_NONRED]    = s_ff.nonred;
                end
                sipc_pkg::A_CFG_ADDR: rd = s_ff.cfg_addr;
                sipc_pkg::A_STATUS: begin
                    rd[sipc_pkg::ST_MODE_LSB +: 2]  = s_ff.mode;
                    rd[sipc_pkg::ST_ADDR_SEL]       = s_ff.addr_sel;
                    rd[sipc_pkg::ST_DUP]            = s_ff.dup;
                    rd[sipc_pkg::ST_DYN]            = s_ff.dyn;
                    rd[sipc_pkg::ST_PHASE_LSB +: 3] = s_ff.phase;
                    rd[sipc_pkg::ST_SVC_LSB +: 7]   = s_ff.svc;
                end
                sipc_pkg::A_CUR_ADDR: rd = s_ff.net_addr;
                sipc_pkg::A_WDT_MS: rd[15:0] = s_ff.wdt_ms;
                sipc_pkg::A_ARP_MS: rd[15:0] = s_ff.arp_ms;
                default: rd = '0;
            endcase
            nxt_s.prdata = rd;
            nxt_s.slverr = !reg_hit(PADDR);
        end

        if (wr_w) begin
            unique case (PADDR)
                sipc_pkg::A_CTRL: begin
                    nxt_s.cfg_valid = PWDATA[sipc_pkg::CTRL_CFG_VALID];
                    nxt_s.nonred    = PWDATA[sipc_pkg::CTRL_NONRED];
                end
                sipc_pkg::A_CFG_ADDR: nxt_s.cfg_addr = PWDATA;
                sipc_pkg::A_WDT_MS:   nxt_s.wdt_ms = PWDATA[15:0];
                sipc_pkg::A_ARP_MS:   nxt_s.arp_ms = PWDATA[15:0];
                default: ;
            endcase
        end

        unique case (s_ff.phase)
            sipc_pkg::PH_BOOT: begin
                if (start_w && !nxt_s.cfg_valid) begin
                    nxt_s.dyn   = 1'b1;
                    nxt_s.mode  = sipc_pkg::MODE_STANDALONE;
                    nxt_s.svc   = sipc_pkg::SVC_ALL;
                    nxt_s.phase = sipc_pkg::PH_IDLE;
                end else if (start_w) begin
                    nxt_s.arp_tx = 1'b1;
                    wdt_start    = 1'b1;
                    wdt_tmo      = s_ff.arp_ms;
                    nxt_s.phase  = sipc_pkg::PH_PROBE;
                end
            end
            sipc_pkg::PH_PROBE: begin
                if (ARP_REPLY || wdt_exp) begin
                    nxt_s.dup      = ARP_REPLY;
                    nxt_s.mode     = ev_mode;
                    nxt_s.svc      = svc_for(ev_mode);
                    nxt_s.addr_sel = ARP_REPLY ? 1'b0 : addr_for(REDUNDANCY_STATE);
                    nxt_s.phase    = sipc_pkg::PH_IDLE;
                end
            end
            sipc_pkg::PH_IDLE: begin
                if (go_in) begin
                    nxt_s.svc    = sipc_pkg::SVC_NONE;
                    nxt_s.req_tx = 1'b1;
                    wdt_start    = 1'b1;
                    nxt_s.phase  = sipc_pkg::PH_IN_WAIT;
                end else if (go_out) begin
                    nxt_s.mode  = sipc_pkg::MODE_OFFLINE;
                    wdt_start   = 1'b1;
                    nxt_s.phase = sipc_pkg::PH_OUT_WAIT;
                end else if (go_off) begin
                    nxt_s.mode = sipc_pkg::MODE_OFFLINE;
                    nxt_s.svc  = svc_for(sipc_pkg::MODE_OFFLINE);
                end else if (back_sb) begin
                    nxt_s.mode = sipc_pkg::MODE_SECONDARY;
                    nxt_s.svc  = svc_for(sipc_pkg::MODE_SECONDARY);
                end else if (reload_w) begin
                    nxt_s.mode     = ev_mode;
                    nxt_s.svc      = svc_for(ev_mode);
                    nxt_s.addr_sel = addr_for(REDUNDANCY_STATE);
                end
                if (s_ff.mode == sipc_pkg::MODE_OFFLINE && PEER_TO_PRIMARY && !s_ff.addr_sel) begin
                    nxt_s.addr_sel = 1'b1;
                end
            end
            sipc_pkg::PH_OUT_WAIT: begin
                // a request seen in the expiry cycle still earns its response
                if (SWAP_REQ_RX || wdt_exp) begin
                    nxt_s.svc      = sipc_pkg::SVC_NONE;
                    nxt_s.rsp_tx   = SWAP_REQ_RX;
                    nxt_s.addr_sel = 1'b1;
                    nxt_s.phase    = sipc_pkg::PH_SEC_START;
                end
            end
            sipc_pkg::PH_SEC_START: begin
                nxt_s.svc    = sipc_pkg::SVC_SERVER;
                nxt_s.listen = 1'b1;
                nxt_s.phase  = sipc_pkg::PH_IDLE;
            end
            sipc_pkg::PH_IN_WAIT: begin
                if (SWAP_RSP_RX || wdt_exp) begin
                    nxt_s.addr_sel = 1'b0;
                    nxt_s.mode     = sipc_pkg::MODE_PRIMARY;
                    nxt_s.svc      = svc_for(sipc_pkg::MODE_PRIMARY);
                    nxt_s.open_cl  = 1'b1;
                    nxt_s.listen   = 1'b1;
                    nxt_s.phase    = sipc_pkg::PH_IDLE;
                end
            end
            default: nxt_s.phase = sipc_pkg::PH_BOOT;
        endcase

        nxt_s.net_addr = nxt_s.cfg_addr + {31'h0, nxt_s.addr_sel};
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            s_ff        <= '0;
            s_ff.phase  <= sipc_pkg::PH_BOOT;
            s_ff.mode   <= sipc_pkg::MODE_STANDALONE;
            s_ff.wdt_ms <= sipc_pkg::WDT_RST;
            s_ff.arp_ms <= sipc_pkg::ARP_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    sipc_ms_wdt #(
        .CYC_PER_MS (CYC_PER_MS),
        .TMO_W      (sipc_pkg::TMO_W)
    ) u_wdt (
        .clk        (CLK),
        .srst       (SRST),
        .start      (wdt_start),
        .timeout_ms (wdt_tmo),
        .expired    (wdt_exp)
    );

    // =====================================================================
    // outputs
    assign PREADY         = PSEL && PENABLE;
    assign PSLVERR        = PSEL && PENABLE && s_ff.slverr;
    assign PRDATA         = s_ff.prdata;
    assign ARP_REQ_TX     = s_ff.arp_tx;
    assign SWAP_REQ_TX    = s_ff.req_tx;
    assign SWAP_RSP_TX    = s_ff.rsp_tx;
    assign OPEN_CLIENTS   = s_ff.open_cl;
    assign LISTEN_SERVERS = s_ff.listen;
    assign MODE           = s_ff.mode;
    assign ADDR_PLUS_ONE  = s_ff.addr_sel;
    assign USE_DYN_ADDR   = s_ff.dyn;
    assign DUP_ADDR_DIAG  = s_ff.dup;
    assign SVC_EN         = s_ff.svc;
    assign NET_ADDR       = s_ff.net_addr;

    // =====================================================================
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence out_swap_s;
        SWAP_RSP_TX && SVC_EN == sipc_pkg::SVC_NONE && ADDR_PLUS_ONE
        ##1 SVC_EN == sipc_pkg::SVC_SERVER && LISTEN_SERVERS && !OPEN_CLIENTS;
    endsequence

    sequence in_swap_s;
        SVC_EN == sipc_pkg::SVC_NONE && SWAP_REQ_TX && s_ff.phase == sipc_pkg::PH_IN_WAIT;
    endsequence

    mode_map_a : assert property ((s_ff.phase == sipc_pkg::PH_IDLE && reload_w && !go_in && !go_out
        && !go_off && !back_sb) |=> MODE == $past(ev_mode)) else $error("reload mode mismatch");
    standalone_a : assert property ((s_ff.phase == sipc_pkg::PH_PROBE && wdt_exp && !CPU_HEALTHY)
        |=> MODE == sipc_pkg::MODE_STANDALONE) else $error("unhealthy cpu not standalone");
    offline_a : assert property ((s_ff.phase == sipc_pkg::PH_IDLE && !go_in && go_off)
        |=> MODE == sipc_pkg::MODE_OFFLINE) else $error("offline trigger ignored");
    hold_mode_a : assert property ((s_ff.phase == sipc_pkg::PH_IDLE && !trig_w)
        |=> $stable(MODE)) else $error("mode changed without trigger");
    sec_dhcp_a : assert property ((MODE == sipc_pkg::MODE_SECONDARY && s_ff.phase == sipc_pkg::PH_IDLE)
        |-> !SVC_EN[sipc_pkg::SVC_DHCP] && !SVC_EN[sipc_pkg::SVC_SCAN]) else $error("dhcp on in secondary");
    out_wait_a : assert property ((s_ff.phase == sipc_pkg::PH_IDLE && go_out && !go_in)
        |=> s_ff.phase == sipc_pkg::PH_OUT_WAIT && MODE == sipc_pkg::MODE_OFFLINE && $stable(SVC_EN))
        else $error("outgoing wait not entered");
    in_start_a : assert property ((s_ff.phase == sipc_pkg::PH_IDLE && go_in) |=> in_swap_s)
        else $error("incoming swap start wrong");
    out_done_a : assert property ((s_ff.phase == sipc_pkg::PH_OUT_WAIT && SWAP_REQ_RX) |=> out_swap_s)
        else $error("outgoing swap sequence wrong");
    no_rsp_a : assert property ((s_ff.phase == sipc_pkg::PH_OUT_WAIT && !SWAP_REQ_RX && wdt_exp)
        |=> !SWAP_RSP_TX ##1 LISTEN_SERVERS) else $error("response sent after expiry");
    in_done_a : assert property ((s_ff.phase == sipc_pkg::PH_IN_WAIT && (SWAP_RSP_RX || wdt_exp))
        |=> MODE == sipc_pkg::MODE_PRIMARY && !ADDR_PLUS_ONE && OPEN_CLIENTS && LISTEN_SERVERS
        && SVC_EN == sipc_pkg::SVC_ALL) else $error("incoming swap completion wrong");
    plus_one_a : assert property ((s_ff.phase == sipc_pkg::PH_IDLE && MODE == sipc_pkg::MODE_OFFLINE
        && PEER_TO_PRIMARY && !ADDR_PLUS_ONE) |=> ADDR_PLUS_ONE && NET_ADDR == s_ff.cfg_addr + 32'h1)
        else $error("offline address not moved");

endmodule

// [rtl/sipc_pkg.sv]
// constants, types and field layout of the standby address-swap controller
//
// Summary of operation
// - cpu status and state select mode
// - absent, unhealthy or nonredundant gives standalone
// - stopped cpu or offline state gives offline
// - mode re-evaluated only on five triggers
// - primary mode runs every service
// - secondary mode keeps dhcp disabled
// - power-up address follows redundancy state
// - simultaneous power-up: elected primary takes base
// - earlier controller base, later one plus one
// - arp probe, reply within timeout keeps default
// - no configuration: standalone, dynamic address
// - secondary and offline stop scanning, shared data
// - primary to offline: wait for request
// - standby to primary: stop, request, wait
// - outgoing side: stop, respond, plus one, restart
// - no response after outgoing watchdog expiry
// - incoming side: base address, primary services
// - offline to standby makes outgoing side secondary
// - new primary opens clients, listens servers
// - new secondary only listens for servers
// - offline, peer primary: move to plus one
package sipc_pkg;

    // =====================================================================
    // bus and register map
    localparam int          ADDR_W     = 8;
    localparam int          DATA_W     = 32;
    localparam logic [7:0]  A_CTRL     = 8'h00;
    localparam logic [7:0]  A_CFG_ADDR = 8'h04;
    localparam logic [7:0]  A_STATUS   = 8'h08;
    localparam logic [7:0]  A_CUR_ADDR = 8'h0C;
    localparam logic [7:0]  A_WDT_MS   = 8'h10;
    localparam logic [7:0]  A_ARP_MS   = 8'h14;

    // control bits
    localparam int CTRL_CFG_VALID = 0;
    localparam int CTRL_NONRED    = 1;
    localparam int CTRL_START     = 2;
    localparam int CTRL_RELOAD    = 3;

    // status fields
    localparam int ST_MODE_LSB  = 0;
    localparam int ST_ADDR_SEL  = 2;
    localparam int ST_DUP       = 3;
    localparam int ST_DYN       = 4;
    localparam int ST_PHASE_LSB = 8;
    localparam int ST_SVC_LSB   = 16;

    // =====================================================================
    // redundancy state encoding from the cpu
    localparam logic [1:0] RS_UNASSIGNED = 2'h0;
    localparam logic [1:0] RS_PRIMARY    = 2'h1;
    localparam logic [1:0] RS_STANDBY    = 2'h2;
    localparam logic [1:0] RS_OFFLINE    = 2'h3;

    typedef enum logic [1:0] {MODE_STANDALONE, MODE_PRIMARY, MODE_SECONDARY, MODE_OFFLINE} sipc_mode_t;
    typedef enum logic [2:0] {PH_BOOT, PH_PROBE, PH_IDLE, PH_OUT_WAIT, PH_SEC_START, PH_IN_WAIT} sipc_phase_t;

    // =====================================================================
    // service enables, one bit per service
    localparam int         SVC_W      = 7;
    localparam int         SVC_SCAN   = 0;
    localparam int         SVC_GDATA  = 1;
    localparam int         SVC_DHCP   = 6;
    localparam logic [6:0] SVC_ALL    = 7'h7F;
    localparam logic [6:0] SVC_SERVER = 7'h3C;
    localparam logic [6:0] SVC_NONE   = 7'h00;

    // =====================================================================
    // timing
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          MS_NS         = 1000000;
    localparam int          CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
    localparam int          TMO_W         = 16;
    localparam int          SWAP_WDT_MS   = 500;
    localparam int          ARP_WAIT_S    = 3;
    localparam logic [15:0] WDT_RST       = 16'(SWAP_WDT_MS);
    localparam logic [15:0] ARP_RST       = 16'(ARP_WAIT_S * 1000);

endpackage

// [rtl/sipc_ms_wdt.sv]
// millisecond watchdog: prescaled tick counter with a level expiry flag
`timescale 1ns/10ps
module sipc_ms_wdt #(
    parameter int CYC_PER_MS = sipc_pkg::CYC_PER_MS,
    parameter int TMO_W      = sipc_pkg::TMO_W
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // control
    input  wire logic             start,
    input  wire logic [TMO_W-1:0] timeout_ms,
    // result
    output logic                  expired
);

    localparam int PRE_W = $clog2(CYC_PER_MS + 1);

    if (CYC_PER_MS < 1 || TMO_W < 1) begin : g_chk
        $error("watchdog parameters out of range");
    end

    typedef struct packed {
        logic [PRE_W-1:0] pre;
        logic [TMO_W-1:0] ms;
        logic             run;
        logic             exp;
    } sipc_wdt_t;

    sipc_wdt_t w_ff;
    sipc_wdt_t nxt_w;

    // =====================================================================
    // counting
    always_comb begin
        nxt_w = w_ff;
        if (start) begin
            nxt_w = '0;
            nxt_w.run = 1'b1;
        end else if (w_ff.run) begin
            if (w_ff.pre == PRE_W'(CYC_PER_MS - 1)) begin
                nxt_w.pre = '0;
                nxt_w.ms  = w_ff.ms + TMO_W'(1);
                if (w_ff.ms + TMO_W'(1) >= timeout_ms) begin
                    nxt_w.run = 1'b0;
                    nxt_w.exp = 1'b1;
                end
            end else begin
                nxt_w.pre = w_ff.pre + PRE_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            w_ff <= '0;
        end else begin
            w_ff <= nxt_w;
        end
    end

    assign expired = w_ff.exp;

    // held until the next start, so the caller must ignore it outside a wait
    exp_hold_a : assert property (@(posedge clk) disable iff (srst)
        (w_ff.exp && !start) |=> w_ff.exp) else $error("expiry flag dropped without restart");

endmodule

// [verification/sipc_peer_model.sv]
// peer module model: answers a swap request, sends one on command
`timescale 1ns/10ps
module sipc_peer_model (
    // clock
    input  wire logic CLK,
    // swap messages
    input  wire logic REQ_IN,
    input  wire logic SEND_REQ,
    output logic      RSP_OUT,
    output logic      REQ_OUT
);
    logic [3:0] cnt_ff = 4'h0;
    initial begin
        RSP_OUT = 1'b0;
        REQ_OUT = 1'b0;
    end
    // slow answer on purpose, still inside the watchdog
    always @(posedge CLK) begin
        RSP_OUT <= (cnt_ff == 4'h1);
        REQ_OUT <= SEND_REQ;
        cnt_ff  <= (REQ_IN === 1'b1) ? 4'h5 : ((cnt_ff != 4'h0) ? cnt_ff - 4'h1 : 4'h0);
    end
endmodule

// [verification/test_sipc_ctrl.sv]
// self-checking bench for the standby address-swap controller
`timescale 1ns/10ps
module test_sipc_ctrl;
    // ====
    // signals
    logic        CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, ARP_REPLY, SEND_REQ, hit, err;
    logic        CPU_PRESENT, CPU_HEALTHY, CPU_RUNNING, PEER_TO_PRIMARY, SWAP_REQ_RX, SWAP_RSP_RX;
    logic        ARP_REQ_TX, SWAP_REQ_TX, SWAP_RSP_TX, ADDR_PLUS_ONE, USE_DYN_ADDR, DUP_ADDR_DIAG;
    logic        OPEN_CLIENTS, LISTEN_SERVERS;
    logic [1:0]  REDUNDANCY_STATE, MODE;
    logic [6:0]  SVC_EN;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA, NET_ADDR, q;
    int          fail_count = 0;
    int          comparisons = 0;
    localparam logic [31:0] CFG = 32'h0A000005;
    // short ms so the timeouts fit the run
    sipc_ctrl #(.CYC_PER_MS(4)) dut (.CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .CPU_PRESENT, .CPU_HEALTHY, .CPU_RUNNING, .REDUNDANCY_STATE, .PEER_TO_PRIMARY,
        .ARP_REPLY, .SWAP_REQ_RX, .SWAP_RSP_RX, .ARP_REQ_TX, .SWAP_REQ_TX, .SWAP_RSP_TX, .OPEN_CLIENTS,
        .LISTEN_SERVERS, .MODE, .ADDR_PLUS_ONE, .USE_DYN_ADDR, .DUP_ADDR_DIAG, .SVC_EN, .NET_ADDR);
    sipc_peer_model peer (.CLK, .REQ_IN(SWAP_REQ_TX), .SEND_REQ, .RSP_OUT(SWAP_RSP_RX), .REQ_OUT(SWAP_REQ_RX));
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    // ====
    // tasks
    task automatic stop_test(input int extra);
        fail_count += extra;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 9);
        if (n >= 9) stop_test(1);
        q = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    // pulses last one cycle, so look at every cycle
    task automatic watch(ref logic s, input int n);
        hit = 1'b0;
        repeat (n) begin
            @(negedge CLK);
            hit |= (s === 1'b1);
        end
    endtask
    task automatic boot(input logic [1:0] rs, input logic [31:0] ctl);
        @(posedge CLK);
        REDUNDANCY_STATE <= rs;
        SRST <= 1'b1;
        repeat (4) @(posedge CLK);
        SRST <= 1'b0;
        apb(1'b1, 8'h14, 32'h1);
        apb(1'b1, 8'h10, 32'h2);
        apb(1'b1, 8'h04, CFG);
        apb(1'b1, 8'h00, ctl);
    endtask
    // ====
    // main sequence
    initial begin
        {SRST, PSEL, PENABLE, PWRITE, ARP_REPLY, SEND_REQ, PEER_TO_PRIMARY} = 7'h40;
        {CPU_PRESENT, CPU_HEALTHY, CPU_RUNNING, REDUNDANCY_STATE, PADDR, PWDATA} = '0;
        {CPU_PRESENT, CPU_HEALTHY, CPU_RUNNING} = 3'h7;
        repeat (4) @(posedge CLK);
        SRST <= 1'b0;
        apb(1'b0, 8'h10, 32'h0);
        chk("wdt_ms", 32'h1F4, q);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped", 32'h1, 32'(err));
        boot(2'h0, 32'h4);
        watch(USE_DYN_ADDR, 3);
        chk("dyn", 32'h1, 32'(hit));
        chk("mode", 32'h0, 32'(MODE));
        boot(2'h1, 32'h5);
        watch(ARP_REQ_TX, 1);
        chk("arp_req", 32'h1, 32'(hit));
        @(posedge CLK);
        ARP_REPLY <= 1'b1;
        @(posedge CLK);
        ARP_REPLY <= 1'b0;
        watch(DUP_ADDR_DIAG, 3);
        chk("dup", 32'h1, 32'(hit));
        chk("addr", CFG, NET_ADDR);
        @(posedge CLK);
        CPU_RUNNING <= 1'b0;
        PEER_TO_PRIMARY <= 1'b1;
        watch(ARP_REQ_TX, 3);
        chk("mode", 32'h3, 32'(MODE));
        chk("addr", CFG + 32'h1, NET_ADDR);
        @(posedge CLK);
        CPU_RUNNING <= 1'b1;
        PEER_TO_PRIMARY <= 1'b0;
        boot(2'h2, 32'h5);
        watch(SWAP_REQ_TX, 8);
        chk("mode", 32'h2, 32'(MODE));
        chk("addr", CFG + 32'h1, NET_ADDR);
        chk("svc", 32'h3C, 32'(SVC_EN));
        @(posedge CLK);
        REDUNDANCY_STATE <= 2'h1;
        watch(SWAP_REQ_TX, 3);
        chk("req_tx", 32'h1, 32'(hit));
        chk("svc", 32'h0, 32'(SVC_EN));
        watch(OPEN_CLIENTS, 12);
        chk("open", 32'h1, 32'(hit));
        chk("mode", 32'h1, 32'(MODE));
        chk("addr", CFG, NET_ADDR);
        boot(2'h1, 32'h5);
        watch(SWAP_REQ_TX, 8);
        chk("svc", 32'h7F, 32'(SVC_EN));
        @(posedge CLK);
        REDUNDANCY_STATE <= 2'h3;
        watch(SWAP_RSP_TX, 3);
        chk("mode", 32'h3, 32'(MODE));
        chk("svc", 32'h7F, 32'(SVC_EN));
        @(posedge CLK);
        SEND_REQ <= 1'b1;
        @(posedge CLK);
        SEND_REQ <= 1'b0;
        watch(SWAP_RSP_TX, 2);
        chk("rsp_tx", 32'h1, 32'(hit));
        watch(LISTEN_SERVERS, 4);
        chk("listen", 32'h1, 32'(hit));
        chk("addr", CFG + 32'h1, NET_ADDR);
        @(posedge CLK);
        REDUNDANCY_STATE <= 2'h2;
        watch(OPEN_CLIENTS, 3);
        chk("mode", 32'h2, 32'(MODE));
        boot(2'h1, 32'h5);
        watch(SWAP_REQ_TX, 8);
        @(posedge CLK);
        REDUNDANCY_STATE <= 2'h3;
        watch(SWAP_RSP_TX, 11);
        chk("rsp_tx", 32'h0, 32'(hit));
        watch(LISTEN_SERVERS, 3);
        chk("listen", 32'h1, 32'(hit));
        chk("addr", CFG + 32'h1, NET_ADDR);
        stop_test(0);
    end
endmodule
